//--- include/track_ctl_pkg.sv
// constants and types shared by the disk track controller and its ecc helper
// assumes a single 50 MHz clock domain; no software-visible registers
package track_ctl_pkg;
	localparam int PARCEL_W = 16;
	localparam int PARCELS_PER_BLOCK = 2048;
	localparam int WORDS_PER_BLOCK = 512;
	localparam int SECTORS_PER_TRACK = 48;
	localparam int SPINDLES_PER_DRIVE = 4;
	localparam int SECTORS_PER_SPINDLE = 12;
	localparam int LOGICAL_DRIVES = 2;
	localparam int PACKET_PARCELS = 16;
	localparam int DEFECT_BYTES = 16;
	localparam int DEFECT_PARCELS = DEFECT_BYTES / 2;
	localparam int ECC_W = 5;
	localparam int SECT_W = 6;
	localparam int PIDX_W = 11;
	localparam int TRACK_PARCELS = SECTORS_PER_TRACK * PARCELS_PER_BLOCK;
	localparam int TIDX_W = 17;
	localparam logic [PIDX_W-1:0] NO_DEFECT = 11'h7FF;
	localparam logic [PARCEL_W-1:0] ZERO_PARCEL = 16'h0000;
	localparam logic [2:0] FN_READ = 3'h1;
	localparam logic [2:0] FN_WRITE = 3'h2;
	localparam logic [2:0] FN_FORMAT = 3'h3;
	typedef enum logic [2:0] {ST_IDLE, ST_WRITE, ST_WZERO, ST_READ, ST_RSKIP, ST_FORMAT} state_t;
endpackage

//--- rtl/parcel_ecc.sv
// single-error-correcting hamming code over one 16-bit parcel
// assumes purely combinational use from the track controller
`timescale 1ns/1ps
`default_nettype none
module parcel_ecc
	import track_ctl_pkg::*;
(
	input wire logic [PARCEL_W-1:0] data_i,
	input wire logic [ECC_W-1:0] check_i,
	output logic [ECC_W-1:0] check_o,
	output logic [PARCEL_W-1:0] fixed_o,
	output logic error_o
);
	function automatic logic [ECC_W-1:0] hcode(input logic [PARCEL_W-1:0] d);
		logic [ECC_W-1:0] c;
		c = '0;
		for (int i = 0; i < PARCEL_W; i++)
			if (d[i])
				c = c ^ ECC_W'(i + 1);
		return c;
	endfunction
	wire logic [ECC_W-1:0] syndrome;
	assign check_o = hcode(data_i);
	assign syndrome = check_o ^ check_i;
	assign error_o = (syndrome != '0);
	// syndrome names the flipped parcel bit; a single check-bit error flips data bit 0, 1, 3, 7 or 15
	always_comb
	begin
		fixed_o = data_i;
		for (int i = 0; i < PARCEL_W; i++)
			if (syndrome == ECC_W'(i + 1))
				fixed_o[i] = ~data_i[i];
	end
endmodule
`default_nettype wire

//--- rtl/disk_track_controller.sv
// disk track controller: routes functions/status, stages a full track,
// adds/checks ecc, spreads sectors over spindles, handles defect fields.
// assumes host and spindle strobes are synchronous to CLOCK_I.
// Summary of operation
// R1: block is 2048 parcels, whole blocks only
// R2: track holds 48 addressable sectors
// R3: consecutive sectors chain into one operation
// R4: eight spindles as two four-spindle drives
// R5: functions go only to selected drive
// R6: drive status relayed back to host
// R7: buffer holds a complete four-spindle track
// R8: write computes and appends ecc bits
// R9: read checks ecc and corrects data
// R10: 48 sectors spread, 12 per spindle
// R11: write data, zero field, then remainder
// R12: read uses defect address first
// R13: zero field dropped from read data
// R14: format puts defect into id field
// R15: only one dual port active
// R16: drives reachable from either controller path
// R17: data moves in 16-parcel packets; code marks packet ends on host read data only
// R18: sector n lives on spindle n/12
`timescale 1ns/1ps
`default_nettype none
module disk_track_controller
	import track_ctl_pkg::*;
#(
	parameter int NUM_DRIVES = LOGICAL_DRIVES
)
(
	input wire logic CLOCK_I,
	input wire logic RST_B_I,
	input wire logic FUNC_VALID_I,
	input wire logic [2:0] FUNC_CODE_I,
	input wire logic DRIVE_SEL_I,
	input wire logic PORT_SEL_I,
	input wire logic [SECT_W-1:0] START_SECTOR_I,
	input wire logic [SECT_W-1:0] SECTOR_COUNT_I,
	input wire logic [PIDX_W-1:0] DEFECT_ADDR_I,
	input wire logic HOST_VALID_I,
	input wire logic [PARCEL_W-1:0] HOST_DATA_I,
	input wire logic [7:0] SPINDLE_STATUS_I,
	input wire logic DISK_VALID_I,
	input wire logic [PARCEL_W-1:0] DISK_DATA_I,
	input wire logic [ECC_W-1:0] DISK_ECC_I,
	output logic [7:0] SPINDLE_FUNC_EN_O,
	output logic [2:0] SPINDLE_FUNC_O,
	output logic PORT_A_EN_O,
	output logic PORT_B_EN_O,
	output logic [3:0] STATUS_O,
	output logic BUSY_O,
	output logic DISK_WE_O,
	output logic [PARCEL_W-1:0] DISK_DATA_O,
	output logic [ECC_W-1:0] DISK_ECC_O,
	output logic [1:0] DISK_SPINDLE_O,
	output logic [SECT_W-1:0] DISK_SECTOR_O,
	output logic [PIDX_W-1:0] ID_DEFECT_O,
	output logic ID_WE_O,
	output logic HOST_VALID_O,
	output logic [PARCEL_W-1:0] HOST_DATA_O,
	output logic PACKET_END_O,
	output logic ECC_FIXED_O
);
	// track buffer in flip-flops: large, but keeps the whole track staged
	logic [PARCEL_W-1:0] track_mem [TRACK_PARCELS]; // [R7]
	state_t state_reg, state_next;
	logic [SECT_W-1:0] sector_reg, count_reg;
	logic [PIDX_W-1:0] pidx_reg, defect_reg;
	logic [3:0] zcnt_reg;
	logic drive_reg, port_reg;
	logic [7:0] func_en_reg;
	logic [2:0] func_reg;
	logic [3:0] status_reg;
	logic we_reg, hv_reg, pend_reg, fixed_reg, id_we_reg;
	logic [PARCEL_W-1:0] dout_reg, hout_reg;
	logic [ECC_W-1:0] ecc_reg;
	logic [3:0] pkt_reg;
	// buffer block counts from 0 at the start sector, so a loaded track follows any start
	logic [SECT_W-1:0] blk_reg;
	logic busy_reg;
	logic [1:0] spn_reg;
	logic [SECT_W-1:0] lsec_reg;

	function automatic logic [SECT_W-1:0] next_sect(input logic [SECT_W-1:0] s);
		return (s == SECT_W'(SECTORS_PER_TRACK - 1)) ? '0 : s + SECT_W'(1); // [R3]
	endfunction

	// fixed sector-to-spindle map keeps each sector on one spindle
	function automatic logic [1:0] spindle_of(input logic [SECT_W-1:0] s);
		return 2'(s / SECTORS_PER_SPINDLE); // [R10] [R18]
	endfunction
	function automatic logic [SECT_W-1:0] local_of(input logic [SECT_W-1:0] s);
		return SECT_W'(s % SECTORS_PER_SPINDLE); // [R10]
	endfunction
	function automatic logic [TIDX_W-1:0] tidx(input logic [SECT_W-1:0] s,
		input logic [PIDX_W-1:0] p);
		return TIDX_W'(s * PARCELS_PER_BLOCK + p);
	endfunction

	wire logic [ECC_W-1:0] wr_check;
	wire logic [PARCEL_W-1:0] rd_fixed;
	wire logic rd_error;
	wire logic [PARCEL_W-1:0] buf_word;
	wire logic last_parcel;
	wire logic last_sector;
	wire logic at_defect;
	wire logic zero_done;
	wire logic start;
	wire logic [7:0] sel_mask;
	wire logic [3:0] status_sel;

	assign buf_word = track_mem[tidx(blk_reg, pidx_reg)];
	assign last_parcel = (pidx_reg == PIDX_W'(PARCELS_PER_BLOCK - 1)); // [R1]
	assign last_sector = (count_reg == SECT_W'(1)); // [R3]
	assign at_defect = (defect_reg != NO_DEFECT) && (pidx_reg == defect_reg); // [R12]
	// the defect-index cycle itself is the first zero parcel of the field
	assign zero_done = (zcnt_reg == 4'(DEFECT_PARCELS - 2)); // [R11] [R13]
	assign start = FUNC_VALID_I && (state_reg == ST_IDLE) && !busy_reg;
	assign sel_mask = DRIVE_SEL_I ? 8'hF0 : 8'h0F; // [R4] [R5]
	assign status_sel = drive_reg ? SPINDLE_STATUS_I[7:4] : SPINDLE_STATUS_I[3:0]; // [R6]

	parcel_ecc u_ecc (
		.data_i(state_reg == ST_READ ? DISK_DATA_I : buf_word),
		.check_i(DISK_ECC_I),
		.check_o(wr_check),
		.fixed_o(rd_fixed),
		.error_o(rd_error)
	);

	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE:
				if (start && FUNC_CODE_I == FN_WRITE)
					state_next = ST_WRITE;
				else if (start && FUNC_CODE_I == FN_READ)
					state_next = ST_READ;
				else if (start && FUNC_CODE_I == FN_FORMAT)
					state_next = ST_FORMAT;
			ST_WRITE:
				if (at_defect)
					state_next = ST_WZERO; // [R11]
				else if (last_parcel && last_sector)
					state_next = ST_IDLE;
			ST_WZERO:
				if (zero_done)
					state_next = ST_WRITE; // [R11]
			ST_READ:
				if (DISK_VALID_I && at_defect)
					state_next = ST_RSKIP; // [R13]
				else if (DISK_VALID_I && last_parcel && last_sector)
					state_next = ST_IDLE;
			ST_RSKIP:
				if (DISK_VALID_I && zero_done)
					state_next = ST_READ; // [R13]
			ST_FORMAT:
				state_next = ST_IDLE;
		endcase
	end

	// host write data fills the track buffer whenever HOST_VALID_I is high, in any state; the index advances only while idle
	always_ff @(posedge CLOCK_I)
	begin
		if (HOST_VALID_I)
			track_mem[tidx(blk_reg, pidx_reg)] <= HOST_DATA_I; // [R7]
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (!RST_B_I)
		begin
			state_reg <= ST_IDLE;
			sector_reg <= '0;
			count_reg <= '0;
			pidx_reg <= '0;
			defect_reg <= NO_DEFECT;
			zcnt_reg <= '0;
			drive_reg <= 1'b0;
			port_reg <= 1'b0;
			func_en_reg <= '0;
			func_reg <= '0;
			blk_reg <= '0;
			busy_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			// held through the last write parcel leaving the output stage
			busy_reg <= (state_next != ST_IDLE) || (state_reg != ST_IDLE);
			func_en_reg <= start ? sel_mask : '0; // [R5]
			func_reg <= start ? FUNC_CODE_I : '0;
			if (start)
			begin
				drive_reg <= DRIVE_SEL_I; // [R4]
				port_reg <= PORT_SEL_I; // [R15] [R16]
				sector_reg <= START_SECTOR_I; // [R2]
				count_reg <= SECTOR_COUNT_I;
				defect_reg <= DEFECT_ADDR_I; // [R12]
				pidx_reg <= '0;
				blk_reg <= '0;
			end
			else if (HOST_VALID_I && state_reg == ST_IDLE)
			begin
				pidx_reg <= pidx_reg + PIDX_W'(1);
				if (last_parcel)
					blk_reg <= next_sect(blk_reg); // [R7]
			end
			zcnt_reg <= (state_reg == ST_WZERO || (state_reg == ST_RSKIP && DISK_VALID_I))
				? zcnt_reg + 4'(1) : '0;
			// defect parcel is consumed by the zero field, so the index advances past it
			if ((state_reg == ST_WRITE && !at_defect)
				|| (state_reg == ST_READ && DISK_VALID_I && !at_defect)
				|| (state_next == ST_WRITE && state_reg == ST_WZERO)
				|| (state_next == ST_READ && state_reg == ST_RSKIP))
			begin
				pidx_reg <= last_parcel ? '0 : pidx_reg + PIDX_W'(1);
				if (last_parcel)
				begin
					sector_reg <= next_sect(sector_reg); // [R3]
					blk_reg <= next_sect(blk_reg);
					count_reg <= count_reg - SECT_W'(1);
				end
			end
			if (state_reg != ST_IDLE && state_next == ST_IDLE)
				blk_reg <= '0;
		end
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (!RST_B_I)
		begin
			status_reg <= '0;
			we_reg <= 1'b0;
			dout_reg <= '0;
			ecc_reg <= '0;
			hv_reg <= 1'b0;
			hout_reg <= '0;
			pkt_reg <= '0;
			pend_reg <= 1'b0;
			fixed_reg <= 1'b0;
			id_we_reg <= 1'b0;
			spn_reg <= '0;
			lsec_reg <= '0;
		end
		else
		begin
			status_reg <= status_sel; // [R6]
			// address staged with the parcel so a sector change cannot skew it
			spn_reg <= spindle_of(sector_reg); // [R10]
			lsec_reg <= local_of(sector_reg); // [R10]
			we_reg <= (state_reg == ST_WRITE || state_reg == ST_WZERO);
			dout_reg <= (state_reg == ST_WZERO || at_defect) ? ZERO_PARCEL : buf_word; // [R11]
			ecc_reg <= (state_reg == ST_WZERO || at_defect) ? '0 : wr_check; // [R8]
			hv_reg <= (state_reg == ST_READ) && DISK_VALID_I && !at_defect; // [R13]
			hout_reg <= rd_fixed; // [R9]
			fixed_reg <= (state_reg == ST_READ) && DISK_VALID_I && rd_error; // [R9]
			id_we_reg <= (state_reg == ST_FORMAT); // [R14]
			if ((state_reg == ST_READ) && DISK_VALID_I && !at_defect)
			begin
				pkt_reg <= pkt_reg + 4'(1); // [R17]
				pend_reg <= (pkt_reg == 4'(PACKET_PARCELS - 1));
			end
			else
				pend_reg <= 1'b0;
		end
	end

	assign SPINDLE_FUNC_EN_O = func_en_reg;
	assign SPINDLE_FUNC_O = func_reg;
	assign PORT_A_EN_O = ~port_reg; // [R15]
	assign PORT_B_EN_O = port_reg; // [R15]
	assign STATUS_O = status_reg;
	assign BUSY_O = busy_reg;
	assign DISK_WE_O = we_reg;
	assign DISK_DATA_O = dout_reg;
	assign DISK_ECC_O = ecc_reg;
	assign DISK_SPINDLE_O = spn_reg;
	assign DISK_SECTOR_O = lsec_reg;
	assign ID_DEFECT_O = defect_reg; // [R14]
	assign ID_WE_O = id_we_reg;
	assign HOST_VALID_O = hv_reg;
	assign HOST_DATA_O = hout_reg;
	assign PACKET_END_O = pend_reg;
	assign ECC_FIXED_O = fixed_reg;
endmodule
`default_nettype wire

//--- sim/dtc_monitor.sv
// port checker for the disk track controller
// assumes it is bound to the top module
`timescale 1ns/1ps
`default_nettype none
module dtc_monitor
	import track_ctl_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic RST_B_I,
	input wire logic FUNC_VALID_I,
	input wire logic [2:0] FUNC_CODE_I,
	input wire logic DRIVE_SEL_I,
	input wire logic BUSY_O,
	input wire logic [7:0] SPINDLE_FUNC_EN_O,
	input wire logic PORT_A_EN_O,
	input wire logic PORT_B_EN_O,
	input wire logic DISK_WE_O,
	input wire logic [SECT_W-1:0] DISK_SECTOR_O,
	input wire logic ID_WE_O,
	input wire logic HOST_VALID_O,
	input wire logic DISK_VALID_I,
	input wire logic PACKET_END_O
);
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RST_B_I);
	// codes 4..7 are not functions, so not counted as a take
	wire take = FUNC_VALID_I && !BUSY_O && FUNC_CODE_I != 3'h0 && !FUNC_CODE_I[2];
	a_port_one_hot: assert property (PORT_A_EN_O != PORT_B_EN_O)
		else $error("port enables not exclusive");
	a_func_drive_mask: assert property (take |=>
		SPINDLE_FUNC_EN_O == ($past(DRIVE_SEL_I) ? 8'hF0 : 8'h0F))
		else $error("function mask wrong");
	a_take_busy: assert property (take |=> BUSY_O)
		else $error("busy missing after take");
	a_refuse_busy: assert property (FUNC_VALID_I && BUSY_O |=> SPINDLE_FUNC_EN_O == 8'h00)
		else $error("function passed while busy");
	a_func_pulse: assert property (SPINDLE_FUNC_EN_O != 8'h00 |=> SPINDLE_FUNC_EN_O == 8'h00)
		else $error("function mask not a pulse");
	a_read_lag: assert property (HOST_VALID_O |-> $past(DISK_VALID_I))
		else $error("host parcel without disk parcel");
	a_pkt_valid: assert property (PACKET_END_O |-> HOST_VALID_O)
		else $error("packet end without parcel");
	a_sector_range: assert property (DISK_WE_O |-> DISK_SECTOR_O < 6'h0C && BUSY_O)
		else $error("bad spindle sector or idle write");
	a_id_pulse: assert property (ID_WE_O |=> !ID_WE_O)
		else $error("id write not a pulse");
endmodule
bind disk_track_controller dtc_monitor dtc_monitor_inst (.CLOCK_I, .RST_B_I, .FUNC_VALID_I,
	.FUNC_CODE_I, .DRIVE_SEL_I, .BUSY_O, .SPINDLE_FUNC_EN_O, .PORT_A_EN_O, .PORT_B_EN_O,
	.DISK_WE_O, .DISK_SECTOR_O, .ID_WE_O, .HOST_VALID_O, .DISK_VALID_I, .PACKET_END_O);
`default_nettype wire

//--- sim/spindle_store.sv
// spindle side model: keeps written parcels, replays them on read
// assumes strobes sampled on rising edge; drives on falling edge
`timescale 1ns/1ps
`default_nettype none
module spindle_store
	import track_ctl_pkg::*;
(
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [PARCEL_W-1:0] wdata_i,
	input wire logic [ECC_W-1:0] wecc_i,
	input wire logic [7:0] func_en_i,
	input wire logic [2:0] func_i,
	output logic valid_o,
	output logic [PARCEL_W-1:0] data_o,
	output logic [ECC_W-1:0] ecc_o
);
	logic [20:0] mem[$];
	initial
	begin
		valid_o = 1'b0;
		data_o = 16'h0000;
		ecc_o = 5'h00;
		forever
		begin
			@(posedge clk_i);
			if (func_en_i != 8'h00 && func_i == FN_WRITE)
				mem.delete();
			if (we_i)
				mem.push_back({wecc_i, wdata_i});
			if (func_en_i != 8'h00 && func_i == FN_READ)
			begin
				// one data bit flipped in parcel 100 to exercise correction
				foreach (mem[i])
				begin
					@(negedge clk_i);
					valid_o = 1'b1;
					{ecc_o, data_o} = mem[i] ^ ((i == 100) ? 21'h8 : 21'h0);
				end
				@(negedge clk_i);
				valid_o = 1'b0;
				data_o = ~data_o;
			end
		end
	end
endmodule
`default_nettype wire

//--- sim/tb_disk_track_controller.sv
// self-checking bench for the disk track controller
// assumes the spindle store model and the bound port monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((e) !== (g)) begin err_count++; \
	$display("mismatch %s exp %h got %h", n, e, g); end end
module tb_disk_track_controller import track_ctl_pkg::*;;
	logic clk = 1'b0, rst_b = 1'b0, fv = 1'b0, dsel = 1'b0, psel = 1'b0, hv = 1'b0;
	logic [2:0] fc = 3'h0, fo;
	logic [5:0] ss = 6'h00, sc = 6'h01, sec;
	logic [10:0] da = NO_DEFECT, idd;
	logic [15:0] hd = 16'h0000, dd, wd, hdo;
	logic [15:0] mem_d[4096];
	logic [7:0] st = 8'h00, fen;
	logic [4:0] de, wecc;
	logic [3:0] sto;
	logic [1:0] spn;
	logic [23:0] exp_v;
	logic dv, pa, pb, busy, we, idwe, ho, pe, fix;
	logic [23:0] wq[$];
	logic [15:0] rq[$];
	int seed = 23, err_count = 0, checks_done = 0, cyc = 0, rn = 0, nfix = 0;
	localparam logic [10:0] DEF = 11'h258;
	disk_track_controller disk_track_controller_inst (.CLOCK_I(clk), .RST_B_I(rst_b),
		.FUNC_VALID_I(fv), .FUNC_CODE_I(fc), .DRIVE_SEL_I(dsel), .PORT_SEL_I(psel),
		.START_SECTOR_I(ss), .SECTOR_COUNT_I(sc), .DEFECT_ADDR_I(da), .HOST_VALID_I(hv),
		.HOST_DATA_I(hd), .SPINDLE_STATUS_I(st), .DISK_VALID_I(dv), .DISK_DATA_I(dd),
		.DISK_ECC_I(de), .SPINDLE_FUNC_EN_O(fen), .SPINDLE_FUNC_O(fo), .PORT_A_EN_O(pa),
		.PORT_B_EN_O(pb), .STATUS_O(sto), .BUSY_O(busy), .DISK_WE_O(we), .DISK_DATA_O(wd),
		.DISK_ECC_O(wecc), .DISK_SPINDLE_O(spn), .DISK_SECTOR_O(sec), .ID_DEFECT_O(idd),
		.ID_WE_O(idwe), .HOST_VALID_O(ho), .HOST_DATA_O(hdo), .PACKET_END_O(pe),
		.ECC_FIXED_O(fix));
	spindle_store spindle_store_inst (.clk_i(clk), .we_i(we), .wdata_i(wd), .wecc_i(wecc),
		.func_en_i(fen), .func_i(fo), .valid_o(dv), .data_o(dd), .ecc_o(de));
	initial forever #10 clk = ~clk;
	task end_of_test;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task func(input logic [2:0] c, input logic [5:0] s, input logic [5:0] n);
		@(negedge clk);
		fc = c;
		ss = s;
		sc = n;
		fv = 1'b1;
		@(negedge clk);
		fv = 1'b0;
	endtask
	// bounded by the global cycle ceiling
	task wait_idle;
		repeat (2) @(negedge clk);
		while (busy !== 1'b0)
			@(negedge clk);
		repeat (4) @(negedge clk);
	endtask
	always @(negedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			err_count++;
			end_of_test;
		end
		if (we)
		begin
			exp_v = wq.pop_front();
			`CHK("wr", exp_v, {spn, sec, wd})
		end
		if (ho)
		begin
			exp_v = {8'h00, rq.pop_front()};
			`CHK("rd", exp_v[15:0], hdo)
			`CHK("pkt", rn % 16 == 15, pe)
			rn++;
		end
		nfix += fix;
	end
	initial
	begin
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		`CHK("porta", 1'b1, pa)
		`CHK("iddef", NO_DEFECT, idd)
		for (int i = 0; i < 4096; i++)
		begin
			mem_d[i] = $random(seed);
			hd = mem_d[i];
			hv = 1'b1;
			@(negedge clk);
		end
		hv = 1'b0;
		// sectors 47 then 0: spindle 3 slot 11, then spindle 0 slot 0
		for (int i = 0; i < 4096; i++)
			if (i % 2048 == DEF)
				repeat (8) wq.push_back({(i < 2048) ? 8'hCB : 8'h00, ZERO_PARCEL});
			else
			begin
				wq.push_back({(i < 2048) ? 8'hCB : 8'h00, mem_d[i]});
				rq.push_back(mem_d[i]);
			end
		dsel = 1'b1;
		psel = 1'b1;
		st = $random(seed);
		da = DEF;
		func(FN_WRITE, 6'h2F, 6'h02);
		func(FN_READ, 6'h00, 6'h01);
		`CHK("portb", 1'b1, pb)
		`CHK("status", st[7:4], sto)
		wait_idle;
		`CHK("wrleft", 0, wq.size())
		func(FN_READ, 6'h2F, 6'h02);
		wait_idle;
		`CHK("rdleft", 0, rq.size())
		`CHK("fixed", 1, nfix)
		dsel = 1'b0;
		psel = 1'b0;
		da = 11'h0A5;
		func(FN_FORMAT, 6'h05, 6'h01);
		while (idwe !== 1'b1)
			@(negedge clk);
		`CHK("iddef", 11'h0A5, idd)
		`CHK("porta", 1'b1, pa)
		end_of_test;
	end
endmodule
`default_nettype wire
